// ==== hw/psa_prog_addr_gen.sv ====
module psa_prog_addr_gen
  import psa_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_n,
  input  wire logic [RA_W-1:0] i_reg_addr,
  input  wire logic [DW-1:0]   i_reg_wdata,
  input  wire logic            i_reg_wr,
  input  wire logic            i_reg_rd,
  output logic      [DW-1:0]   o_reg_rdata,
  input  wire logic            i_fetch_req,
  input  wire logic [PC_W-1:0] i_pc,
  output logic                 o_fetch_ack,
  output logic                 o_fetch_valid,
  output logic      [PA_W-1:0] o_fetch_word,
  output logic      [PC_W-1:0] o_fetch_next_pc,
  input  wire logic            i_x_req,
  input  wire psa_op_e         i_x_op,
  input  wire psa_cls_e        i_x_cls,
  input  wire logic [EA_W-1:0] i_x_eff_addr,
  input  wire logic            i_x_byte,
  input  wire logic [DW-1:0]   i_x_wdata,
  input  wire logic            i_rpt_active,
  input  wire logic            i_rpt_first,
  input  wire logic            i_rpt_last,
  input  wire logic            i_rpt_irq_exit,
  input  wire logic            i_rpt_irq_reentry,
  output logic                 o_x_taken,
  output logic                 o_stall,
  output logic                 o_x_rvalid,
  output logic      [DW-1:0]   o_x_rdata,
  output logic                 o_x_ram_req,
  output logic                 o_x_ram_wr,
  output logic      [EA_W-1:0] o_x_ram_addr,
  input  wire logic            i_y_req,
  input  wire logic [EA_W-1:0] i_y_eff_addr,
  output logic                 o_y_ram_req,
  output logic      [EA_W-1:0] o_y_ram_addr,
  output logic                 o_y_zero,
  output logic      [PA_W-1:0] o_pm_addr,
  output logic                 o_pm_rd,
  output logic                 o_pm_wr_low,
  output logic                 o_pm_wr_high,
  output logic      [DW-1:0]   o_pm_wdata,
  input  wire logic [PA_W-1:0] i_pm_rdata
);
  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_HOLD} psa_state_e;

  psa_state_e      state_r;
  logic [PG_W-1:0] tbl_page_r;
  logic [PG_W-1:0] cw_page_r;
  logic            cw_en_r;
  logic [1:0]      stall_cnt_r;
  logic            is_fetch_r;
  logic            rd_high_r;
  logic            rd_byte_r;
  logic            rd_sel_r;
  logic            last_win_r;
  logic            last_cfg_r;
  logic [DW-1:0]   fmt_data;
  logic [PA_W-1:0] tbl_addr;
  logic [PA_W-1:0] fetch_addr;
  logic [PC_W-1:0] pc_even;
  logic [1:0]      extra_nxt;
  logic            idle;
  logic            x_go;
  logic            x_is_tbl;
  logic            x_is_data;
  logic            x_tbl_rd;
  logic            x_tbl_wr;
  logic            x_win_rd;
  logic            x_ram;
  logic            pm_claim;
  logic            fetch_go;
  logic            rpt_edge;

  psa_agu_if xb ();
  psa_agu_if yb ();

  // Two independent address units, one for each data path
  psa_addr_gen_unit #(.IS_Y_SPACE(1'b0)) u_x_unit (.bus(xb)); // RULE17
  psa_addr_gen_unit #(.IS_Y_SPACE(1'b1)) u_y_unit (.bus(yb)); // RULE17

  psa_rd_fmt u_fmt (
    .i_word      (i_pm_rdata),
    .i_high_half (rd_high_r),
    .i_byte      (rd_byte_r),
    .i_byte_sel  (rd_sel_r),
    .o_data      (fmt_data)
  );

  assign x_is_tbl  = (i_x_op == OP_TBL_RDL) || (i_x_op == OP_TBL_RDH) ||
                     (i_x_op == OP_TBL_WTL) || (i_x_op == OP_TBL_WTH);
  assign x_is_data = (i_x_op == OP_DATA_RD) || (i_x_op == OP_DATA_WR);

  assign xb.eff_addr = i_x_eff_addr;
  assign xb.req      = i_x_req && x_is_data;
  assign xb.table_op = i_x_req && x_is_tbl; // RULE13
  assign xb.win_en   = cw_en_r;
  assign xb.win_page = cw_page_r;
  assign yb.eff_addr = i_y_eff_addr;
  assign yb.req      = i_y_req;
  assign yb.table_op = 1'b0;
  assign yb.win_en   = cw_en_r;
  assign yb.win_page = cw_page_r;

  assign idle     = (state_r == ST_IDLE);
  assign x_go     = idle && i_x_req;
  assign x_tbl_rd = x_go && ((i_x_op == OP_TBL_RDL) || (i_x_op == OP_TBL_RDH));
  assign x_tbl_wr = x_go && ((i_x_op == OP_TBL_WTL) || (i_x_op == OP_TBL_WTH));
  assign x_win_rd = x_go && (i_x_op == OP_DATA_RD) && xb.win_hit; // RULE10
  assign x_ram    = x_go && xb.ram_hit;
  assign pm_claim = x_tbl_rd || x_tbl_wr || x_win_rd;
  assign fetch_go = idle && i_fetch_req && !pm_claim;

  assign tbl_addr   = {tbl_page_r, i_x_eff_addr}; // RULE3 RULE4 RULE5
  assign pc_even    = {i_pc[PC_W-1:1], 1'b0};
  assign fetch_addr = {1'b0, pc_even}; // RULE1 RULE3

  assign rpt_edge = i_rpt_first || i_rpt_last || i_rpt_irq_exit || i_rpt_irq_reentry;

  always_comb begin
    extra_nxt = EXTRA_NONE;
    if (x_win_rd) begin
      if (i_rpt_active) begin
        extra_nxt = rpt_edge ? EXTRA_LONG : EXTRA_NONE; // RULE15
      end else if (i_x_cls == CLS_OTHER) begin
        extra_nxt = EXTRA_LONG; // RULE14
      end else begin
        extra_nxt = EXTRA_SHORT; // RULE14
      end
    end
  end

  // Software-visible registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tbl_page_r <= PAGE_RST;
      cw_page_r  <= PAGE_RST;
      cw_en_r    <= CW_EN_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        REG_TBL_PAGE:  tbl_page_r <= i_reg_wdata[PG_W-1:0];
        REG_CW_PAGE:   cw_page_r  <= i_reg_wdata[PG_W-1:0];
        REG_CORE_CTRL: cw_en_r    <= i_reg_wdata[CW_EN_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= '0;
      case (i_reg_addr)
        REG_TBL_PAGE:  o_reg_rdata[PG_W-1:0]  <= tbl_page_r;
        REG_CW_PAGE:   o_reg_rdata[PG_W-1:0]  <= cw_page_r;
        REG_CORE_CTRL: o_reg_rdata[CW_EN_BIT] <= cw_en_r;
        REG_STATUS: begin
          o_reg_rdata[ST_BUSY_BIT] <= !idle;
          o_reg_rdata[ST_WIN_BIT]  <= last_win_r;
          o_reg_rdata[ST_CFG_BIT]  <= last_cfg_r;
        end
        default: ;
      endcase
    end else begin
      o_reg_rdata <= '0;
    end
  end

  // Sequencer and stall count
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r     <= ST_IDLE;
      stall_cnt_r <= EXTRA_NONE;
      o_stall     <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (x_tbl_rd || x_win_rd || fetch_go) begin
            state_r <= ST_PROG;
          end
          stall_cnt_r <= extra_nxt;
          o_stall     <= (extra_nxt != EXTRA_NONE); // RULE19
        end
        ST_PROG: begin
          state_r <= (stall_cnt_r > EXTRA_SHORT) ? ST_HOLD : ST_IDLE;
        end
        ST_HOLD: begin
          if (stall_cnt_r <= EXTRA_SHORT) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (state_r != ST_IDLE) begin
        if (stall_cnt_r != EXTRA_NONE) begin
          stall_cnt_r <= stall_cnt_r - EXTRA_SHORT;
        end
        o_stall <= (stall_cnt_r > EXTRA_SHORT); // RULE14 RULE15 RULE19
      end
    end
  end

  // Program memory port
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pm_addr    <= '0;
      o_pm_rd      <= 1'b0;
      o_pm_wr_low  <= 1'b0;
      o_pm_wr_high <= 1'b0;
      o_pm_wdata   <= '0;
      is_fetch_r   <= 1'b0;
      rd_high_r    <= 1'b0;
      rd_byte_r    <= 1'b0;
      rd_sel_r     <= 1'b0;
      last_win_r   <= 1'b0;
      last_cfg_r   <= 1'b0;
    end else begin
      o_pm_rd      <= x_tbl_rd || x_win_rd || fetch_go;
      o_pm_wr_low  <= x_tbl_wr && (i_x_op == OP_TBL_WTL); // RULE18
      o_pm_wr_high <= x_tbl_wr && (i_x_op == OP_TBL_WTH); // RULE18
      if (x_tbl_rd || x_tbl_wr) begin
        o_pm_addr  <= tbl_addr; // RULE5
        o_pm_wdata <= i_x_wdata; // RULE18
        is_fetch_r <= 1'b0;
        rd_high_r  <= (i_x_op == OP_TBL_RDH); // RULE9
        rd_byte_r  <= i_x_byte;
        rd_sel_r   <= i_x_eff_addr[0];
        last_win_r <= 1'b0;
        last_cfg_r <= tbl_page_r[CFG_SEL_BIT]; // RULE3
      end else if (x_win_rd) begin
        o_pm_addr  <= xb.win_addr; // RULE6 RULE11
        is_fetch_r <= 1'b0;
        rd_high_r  <= 1'b0; // RULE9 RULE12
        rd_byte_r  <= i_x_byte;
        rd_sel_r   <= i_x_eff_addr[0];
        last_win_r <= 1'b1;
        last_cfg_r <= 1'b0;
      end else if (fetch_go) begin
        o_pm_addr  <= fetch_addr; // RULE1
        is_fetch_r <= 1'b1;
      end
    end
  end

  // Returned table and window data, held until the next read is taken
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_x_rvalid <= 1'b0;
      o_x_rdata  <= '0;
      o_x_taken  <= 1'b0;
    end else begin
      o_x_taken <= x_go;
      if (x_tbl_rd || x_win_rd) begin
        o_x_rvalid <= 1'b0;
      end else if (state_r == ST_PROG && !is_fetch_r) begin
        o_x_rvalid <= 1'b1;
        o_x_rdata  <= fmt_data; // RULE7 RULE8 RULE12 RULE19
      end
    end
  end

  // Instruction fetch return
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fetch_ack     <= 1'b0;
      o_fetch_valid   <= 1'b0;
      o_fetch_word    <= '0;
      o_fetch_next_pc <= '0;
    end else begin
      o_fetch_ack   <= fetch_go;
      o_fetch_valid <= (state_r == ST_PROG) && is_fetch_r;
      if ((state_r == ST_PROG) && is_fetch_r) begin
        o_fetch_word <= i_pm_rdata;
      end
      if (fetch_go) begin
        o_fetch_next_pc <= pc_even + PC_STEP; // RULE2
      end
    end
  end

  // Data RAM ports of both paths
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_x_ram_req  <= 1'b0;
      o_x_ram_wr   <= 1'b0;
      o_x_ram_addr <= '0;
      o_y_ram_req  <= 1'b0;
      o_y_ram_addr <= '0;
      o_y_zero     <= 1'b0;
    end else begin
      o_x_ram_req  <= x_ram; // RULE10
      o_x_ram_wr   <= x_ram && (i_x_op == OP_DATA_WR);
      o_x_ram_addr <= i_x_eff_addr;
      o_y_ram_req  <= yb.ram_hit; // RULE16 RULE17
      o_y_ram_addr <= i_y_eff_addr;
      o_y_zero     <= i_y_req && !yb.ram_hit; // RULE16
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  fetch_addr_a: assert property (fetch_go |=> o_pm_rd && !o_pm_addr[0] && !o_pm_addr[PA_W-1]) // RULE1
    else $error("fetch address not even or bit 23 set");
  fetch_step_a: assert property (fetch_go |=> o_fetch_next_pc == $past(pc_even) + PC_STEP) // RULE2
    else $error("next fetch address not advanced by two");
  user_space_a: assert property (o_pm_rd && (last_win_r || is_fetch_r) |-> !o_pm_addr[23]) // RULE3
    else $error("non-table access left user space");
  cfg_bit_a: assert property (x_tbl_rd |=> o_pm_addr[23] == $past(tbl_page_r[CFG_SEL_BIT])) // RULE4
    else $error("bit 23 does not follow config select");
  tbl_addr_a: assert property (x_tbl_rd |=> o_pm_addr == {$past(tbl_page_r), $past(i_x_eff_addr)}) // RULE5
    else $error("table address wrong");
  win_addr_a: assert property (x_win_rd |=>
      o_pm_addr == {1'b0, $past(cw_page_r), $past(i_x_eff_addr[WIN_LO_W-1:0])}) // RULE6
    else $error("window address wrong");
  // A fetch taken beside a plain data access may legally use the program port
  win_gate_a: assert property (x_go && x_is_data && !(i_x_eff_addr[EA_MSB] && cw_en_r)
      |=> !o_pm_rd || is_fetch_r) // RULE10
    else $error("data access reached program memory without window");
  tbl_no_win_a: assert property (x_go && x_is_tbl |-> !xb.win_hit) // RULE13
    else $error("window active during table op");
  high_zero_a: assert property (x_tbl_rd && i_x_op == OP_TBL_RDH |=> ##1
      o_x_rvalid && o_x_rdata[DW-1:BYTE_W] == '0) // RULE8
    else $error("high table read upper byte not zero");
  win_low_a: assert property (x_win_rd && !i_x_byte |=> ##1
      o_x_rdata == $past(i_pm_rdata[DW-1:0])) // RULE12
    else $error("window read data not low word");
  stall_long_a: assert property (x_win_rd && !i_rpt_active && i_x_cls == CLS_OTHER
      |=> o_stall [*2] ##1 !o_stall) // RULE14
    else $error("two-cycle window stall wrong");
  stall_short_a: assert property (x_win_rd && !i_rpt_active && i_x_cls != CLS_OTHER
      |=> o_stall ##1 !o_stall) // RULE14
    else $error("one-cycle window stall wrong");
  rpt_mid_a: assert property (x_win_rd && i_rpt_active && !rpt_edge |=> !o_stall) // RULE15
    else $error("mid-repeat window access stalled");
  y_upper_a: assert property (i_y_req && i_y_eff_addr[EA_MSB] |=> !o_y_ram_req && o_y_zero) // RULE16
    else $error("Y path reached upper data half");
  hold_data_a: assert property (o_stall && o_x_rvalid |=> $stable(o_x_rdata)) // RULE19
    else $error("returned data changed during stall");
  tbl_write_a: assert property (x_tbl_wr && i_x_op == OP_TBL_WTL
      |=> o_pm_wr_low && !o_pm_wr_high && o_pm_wdata == $past(i_x_wdata)) // RULE18
    else $error("low table write not presented");

  win_read_c: cover property (x_win_rd ##1 o_stall ##1 o_stall ##1 !o_stall);
  tbl_high_c: cover property (x_tbl_rd && i_x_op == OP_TBL_RDH ##2 o_x_rvalid);
  rpt_mid_c: cover property (x_win_rd && i_rpt_active && !rpt_edge);
  fetch_c: cover property (fetch_go ##2 o_fetch_valid);
endmodule

// ==== hw/psa_pkg.sv ====
package psa_pkg;
  // What this block does
  // RULE1: Program addresses are 24 bits; fetch uses 23-bit PC with bit zero cleared.
  // RULE2: Program address steps by two per program word, matching byte data addresses.
  // RULE3: Non-table accesses stay in user space; table page bit 7 picks config space.
  // RULE4: Address bit 23 set only by table accesses with config select; else low.
  // RULE5: Table address is table page in upper byte over the 16-bit data address.
  // RULE6: Window address is zero, window page in bits 22:15, low 15 data bits.
  // RULE7: Low table read gives bits 15:0; byte read picks low or high byte by select.
  // RULE8: High table read gives bits 23:16 in low byte, zero above; byte read with select 1 gives zero.
  // RULE9: Upper program byte is reachable only by high table ops, never by the window.
  // RULE10: Data goes to program memory only when address MSB and window enable set.
  // RULE11: Upper 32 Kbytes of data space map onto the selected 16K-word program page.
  // RULE12: Window read returns only the low 16 bits of the program word.
  // RULE13: Window mapping is suspended during table reads and writes.
  // RULE14: Outside repeat, window read adds one cycle for moves and prefetches, else two.
  // RULE15: Inside repeat, two extra cycles at first, last, interrupt exit and re-entry; else none.
  // RULE16: Upper half of data space belongs to X space only, never to Y space.
  // RULE17: Two independent address units with own data paths serve data accesses.
  // RULE18: Table writes present program word half and write data to flash logic.
  // RULE19: Core stalls for added cycles; returned data stays valid until stall ends.
  localparam int PA_W      = 24;
  localparam int PC_W      = 23;
  localparam int EA_W      = 16;
  localparam int DW        = 16;
  localparam int BYTE_W    = 8;
  localparam int PG_W      = 8;
  localparam int WIN_LO_W  = 15;
  localparam int EA_MSB    = 15;
  localparam int CFG_SEL_BIT = 7;
  localparam int RA_W      = 4;
  localparam logic [RA_W-1:0] REG_TBL_PAGE  = 4'h0;
  localparam logic [RA_W-1:0] REG_CW_PAGE   = 4'h4;
  localparam logic [RA_W-1:0] REG_CORE_CTRL = 4'h8;
  localparam logic [RA_W-1:0] REG_STATUS    = 4'hC;
  localparam int CW_EN_BIT   = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WIN_BIT  = 1;
  localparam int ST_CFG_BIT  = 2;
  localparam logic [PG_W-1:0] PAGE_RST  = 8'h00;
  localparam logic            CW_EN_RST = 1'b0;
  localparam logic [PC_W-1:0] PC_STEP   = 23'h000002;
  localparam logic [1:0] EXTRA_NONE  = 2'h0;
  localparam logic [1:0] EXTRA_SHORT = 2'h1;
  localparam logic [1:0] EXTRA_LONG  = 2'h2;
  typedef enum logic [2:0] {
    OP_DATA_RD, OP_DATA_WR, OP_TBL_RDL, OP_TBL_RDH, OP_TBL_WTL, OP_TBL_WTH
  } psa_op_e;
  typedef enum logic [1:0] {
    CLS_MULT_ACC_PREFETCH, CLS_WORD_MOVE, CLS_DOUBLE_MOVE, CLS_OTHER
  } psa_cls_e;
endpackage

// ==== hw/psa_agu_if.sv ====
interface psa_agu_if;
  import psa_pkg::*;
  logic [EA_W-1:0] eff_addr;
  logic            req;
  logic            table_op;
  logic            win_en;
  logic [PG_W-1:0] win_page;
  logic            win_hit;
  logic            ram_hit;
  logic [PA_W-1:0] win_addr;
  modport unit (input eff_addr, req, table_op, win_en, win_page,
                output win_hit, ram_hit, win_addr);
  modport core (output eff_addr, req, table_op, win_en, win_page,
                input win_hit, ram_hit, win_addr);
endinterface

// ==== hw/psa_addr_gen_unit.sv ====
module psa_addr_gen_unit
  import psa_pkg::*;
#(
  parameter bit IS_Y_SPACE = 1'b0
) (
  psa_agu_if.unit bus
);
  logic upper;
  assign upper = bus.eff_addr[EA_MSB];
  // Window only from X space and never during table ops
  assign bus.win_hit  = !IS_Y_SPACE && bus.req && upper && bus.win_en && !bus.table_op; // RULE10 RULE13 RULE16
  // Upper half seen from Y space is outside its space and reads zero
  assign bus.ram_hit  = bus.req && !bus.win_hit && !(IS_Y_SPACE && upper); // RULE16
  assign bus.win_addr = {1'b0, bus.win_page, bus.eff_addr[WIN_LO_W-1:0]}; // RULE6 RULE11
endmodule

// ==== hw/psa_rd_fmt.sv ====
module psa_rd_fmt
  import psa_pkg::*;
(
  input  wire logic [PA_W-1:0] i_word,
  input  wire logic            i_high_half,
  input  wire logic            i_byte,
  input  wire logic            i_byte_sel,
  output logic      [DW-1:0]   o_data
);
  always_comb begin
    o_data = '0;
    if (i_high_half) begin
      if (!(i_byte && i_byte_sel)) begin
        o_data[BYTE_W-1:0] = i_word[PA_W-1:DW]; // RULE8 RULE9
      end
    end else if (i_byte) begin
      o_data[BYTE_W-1:0] = i_byte_sel ? i_word[DW-1:BYTE_W] : i_word[BYTE_W-1:0]; // RULE7
    end else begin
      o_data = i_word[DW-1:0]; // RULE7 RULE12
    end
  end
endmodule

// ==== verification/psa_flash_model.sv ====
module psa_flash_model
  import psa_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic [PA_W-1:0] i_pm_addr,
  input  wire logic            i_pm_rd,
  output logic      [PA_W-1:0] o_pm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PA_W-1:0] last_r = 24'h5A5A5A;
  logic [PA_W-1:0] word;
  // Array contents are a fixed scramble of the address
  assign word = {i_pm_addr[7:0] ^ 8'hC3, i_pm_addr[23:8] ^ 16'h9E1B};
  // Outside a read the old word is not held, so stale data cannot match by chance
  assign o_pm_rdata = i_pm_rd ? word : ~last_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_pm_rd) begin
      last_r <= word;
    end
  end
endmodule

// ==== verification/psa_prog_addr_gen_tb_top.sv ====
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] t=%0t mismatch got %0h exp %0h", $time, got, exp); end end

module psa_prog_addr_gen_tb_top
  import psa_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic            i_sys_clk, i_rst_n, i_reg_wr, i_reg_rd, i_fetch_req, i_x_req, i_x_byte;
  logic            i_rpt_active, i_rpt_first, i_rpt_last, i_rpt_irq_exit, i_rpt_irq_reentry;
  logic            i_y_req, o_fetch_ack, o_fetch_valid, o_x_taken, o_stall, o_x_rvalid;
  logic            o_x_ram_req, o_x_ram_wr, o_y_ram_req, o_y_zero, o_pm_rd, o_pm_wr_low;
  logic            o_pm_wr_high, cw_en;
  logic            st_win = 1'b0, st_cfg = 1'b0;
  logic [RA_W-1:0] i_reg_addr;
  logic [DW-1:0]   i_reg_wdata, o_reg_rdata, i_x_wdata, o_x_rdata, o_pm_wdata;
  logic [EA_W-1:0] i_x_eff_addr, o_x_ram_addr, i_y_eff_addr, o_y_ram_addr;
  logic [PC_W-1:0] i_pc, o_fetch_next_pc;
  logic [PA_W-1:0] o_fetch_word, o_pm_addr, i_pm_rdata;
  logic [PG_W-1:0] tbl_pg, cw_pg;
  psa_op_e         i_x_op;
  psa_cls_e        i_x_cls;
  logic [31:0]     seed = 32'h0D792F43;
  logic [31:0]     cyc = 32'h00000000;
  int              n_mismatch, total_checks;

  psa_prog_addr_gen i_dut (
    .i_sys_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_fetch_req, .i_pc, .o_fetch_ack, .o_fetch_valid, .o_fetch_word, .o_fetch_next_pc,
    .i_x_req, .i_x_op, .i_x_cls, .i_x_eff_addr, .i_x_byte, .i_x_wdata, .i_rpt_active,
    .i_rpt_first, .i_rpt_last, .i_rpt_irq_exit, .i_rpt_irq_reentry, .o_x_taken, .o_stall,
    .o_x_rvalid, .o_x_rdata, .o_x_ram_req, .o_x_ram_wr, .o_x_ram_addr, .i_y_req,
    .i_y_eff_addr, .o_y_ram_req, .o_y_ram_addr, .o_y_zero, .o_pm_addr, .o_pm_rd,
    .o_pm_wr_low, .o_pm_wr_high, .o_pm_wdata, .i_pm_rdata
  );
  psa_flash_model i_flash (
    .i_sys_clk, .i_pm_addr(o_pm_addr), .i_pm_rd(o_pm_rd), .o_pm_rdata(i_pm_rdata)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [PA_W-1:0] flash(input logic [PA_W-1:0] a);
    return {a[7:0] ^ 8'hC3, a[23:8] ^ 16'h9E1B};
  endfunction
  function automatic logic [DW-1:0] fmt(input logic [PA_W-1:0] w, input logic hi, bt, sel);
    if (hi) return (bt && sel) ? 16'h0000 : {8'h00, w[23:16]};
    if (bt) return {8'h00, sel ? w[15:8] : w[7:0]};
    return w[15:0];
  endfunction

  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 32'h00000001;
    if (cyc == 32'h00001770) begin
      n_mismatch++;
      results();
    end
  end

  task automatic reg_wr(input logic [RA_W-1:0] a, input logic [DW-1:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [RA_W-1:0] a, output logic [DW-1:0] d);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  task automatic set_regs(input logic [PG_W-1:0] t, c, input logic e);
    logic [DW-1:0] d;
    reg_wr(REG_TBL_PAGE, {8'hA5, t});
    reg_wr(REG_CW_PAGE, {8'h5A, c});
    reg_wr(REG_CORE_CTRL, {15'h0000, e});
    tbl_pg = t;
    cw_pg = c;
    cw_en = e;
    reg_rd(REG_TBL_PAGE, d);
    `CHK(d, {8'h00, t});
    reg_rd(REG_CW_PAGE, d);
    `CHK(d, {8'h00, c});
    reg_rd(REG_CORE_CTRL, d);
    `CHK(d, {15'h0000, e});
  endtask

  task automatic fetch(input logic [PC_W-1:0] pc);
    logic [PC_W-1:0] ev;
    ev = {pc[PC_W-1:1], 1'b0};
    @(posedge i_sys_clk);
    i_fetch_req <= 1'b1;
    i_pc <= pc;
    @(posedge i_sys_clk);
    i_fetch_req <= 1'b0;
    #1;
    `CHK({o_fetch_ack, o_pm_rd, o_pm_addr}, {2'b11, 1'b0, ev});
    `CHK(o_fetch_next_pc, ev + PC_STEP);
    @(posedge i_sys_clk);
    #1;
    `CHK({o_fetch_valid, o_fetch_word}, {1'b1, flash({1'b0, ev})});
  endtask

  task automatic x_acc(input psa_op_e op, input psa_cls_e cls, input logic [EA_W-1:0] ea,
                       input logic bt, input logic [4:0] rf);
    logic            tbl, win, rd, wr, rv;
    logic [PA_W-1:0] pa;
    logic [31:0]     r;
    logic [DW-1:0]   d;
    int              ext, nst;
    r = xs();
    d = r[15:0];
    tbl = op inside {OP_TBL_RDL, OP_TBL_RDH, OP_TBL_WTL, OP_TBL_WTH};
    win = !tbl && ea[EA_MSB] && cw_en;
    rd = op inside {OP_TBL_RDL, OP_TBL_RDH} || (win && op == OP_DATA_RD);
    wr = op inside {OP_TBL_WTL, OP_TBL_WTH};
    pa = tbl ? {tbl_pg, ea} : {1'b0, cw_pg, ea[WIN_LO_W-1:0]};
    if (!(win && op == OP_DATA_RD)) ext = 0;
    else if (rf[0]) ext = (rf[4:1] != 4'h0) ? 2 : 0;
    else ext = (cls == CLS_OTHER) ? 2 : 1;
    @(posedge i_sys_clk);
    i_x_req <= 1'b1;
    i_x_op <= op;
    i_x_cls <= cls;
    i_x_eff_addr <= ea;
    i_x_byte <= bt;
    i_x_wdata <= d;
    {i_rpt_irq_reentry, i_rpt_irq_exit, i_rpt_last, i_rpt_first, i_rpt_active} <= rf;
    {i_y_req, i_y_eff_addr} <= {1'b1, r[31:16]};
    @(posedge i_sys_clk);
    i_x_req <= 1'b0;
    i_y_req <= 1'b0;
    #1;
    `CHK(o_x_taken, 1'b1);
    `CHK(o_pm_rd, rd);
    if (rd || wr) `CHK(o_pm_addr, pa);
    `CHK(o_x_ram_req, !tbl && !win);
    if (o_x_ram_req === 1'b1) `CHK({o_x_ram_wr, o_x_ram_addr}, {op == OP_DATA_WR, ea});
    `CHK({o_pm_wr_low, o_pm_wr_high}, {op == OP_TBL_WTL, op == OP_TBL_WTH});
    if (wr) `CHK(o_pm_wdata, d);
    `CHK({o_y_zero, o_y_ram_req}, {r[31], !r[31]});
    if (!r[31]) `CHK(o_y_ram_addr, r[31:16]);
    nst = 0;
    rv = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      if (o_stall === 1'b1) nst++;
      if (i == 2) begin
        rv = o_x_rvalid;
        d = o_x_rdata;
      end
      @(posedge i_sys_clk);
      #1;
    end
    if (!(win && op == OP_DATA_WR)) `CHK(nst, ext);
    if (rd) begin
      `CHK(rv, 1'b1);
      `CHK(d, fmt(flash(pa), op == OP_TBL_RDH, bt, ea[0]));
    end
    // Status remembers whether the last table access or window read (fetches excluded) was window or config table
    if (rd || wr) begin
      st_win = win;
      st_cfg = tbl && tbl_pg[CFG_SEL_BIT];
    end
    reg_rd(REG_STATUS, d);
    `CHK(d, {13'h0000, st_cfg, st_win, 1'b0});
  endtask

  initial begin
    logic [31:0]     r;
    logic [DW-1:0]   d;
    logic [RA_W-1:0] regs[5];
    psa_op_e         tops[4];
    regs = '{REG_TBL_PAGE, REG_CW_PAGE, REG_CORE_CTRL, REG_STATUS, 4'h2};
    tops = '{OP_TBL_RDL, OP_TBL_RDH, OP_TBL_WTL, OP_TBL_WTH};
    {i_rst_n, i_reg_wr, i_reg_rd, i_fetch_req, i_x_req, i_x_byte, i_y_req} = '0;
    {i_rpt_active, i_rpt_first, i_rpt_last, i_rpt_irq_exit, i_rpt_irq_reentry} = '0;
    {i_reg_addr, i_reg_wdata, i_x_wdata, i_x_eff_addr, i_y_eff_addr, i_pc} = '0;
    i_x_op = OP_DATA_RD;
    i_x_cls = CLS_OTHER;
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    foreach (regs[i]) begin
      reg_rd(regs[i], d);
      `CHK(d, 16'h0000);
    end
    // Status is read-only and unmapped places ignore writes
    reg_wr(REG_STATUS, 16'hFFFF);
    reg_wr(4'h2, 16'hFFFF);
    reg_rd(REG_STATUS, d);
    `CHK(d, 16'h0000);
    reg_rd(4'h2, d);
    `CHK(d, 16'h0000);
    $display("Test registers done");
    set_regs(8'h00, 8'h00, 1'b0);
    fetch(23'h7FFFFF);
    fetch(23'h000001);
    for (int i = 0; i < 40; i++) begin
      r = xs();
      fetch(r[PC_W-1:0]);
    end
    $display("Test fetch done");
    set_regs(8'h80, 8'hFF, 1'b1);
    x_acc(OP_TBL_RDH, CLS_OTHER, 16'hFFFF, 1'b1, 5'h00);
    x_acc(OP_TBL_RDL, CLS_OTHER, 16'h8001, 1'b1, 5'h00);
    for (int i = 0; i < 60; i++) begin
      r = xs();
      if (i % 8 == 0) set_regs(r[7:0], r[15:8], r[16]);
      x_acc(tops[r[22:21]], CLS_OTHER, {r[31:17], r[19] & r[20]}, r[19], 5'h00);
    end
    $display("Test table done");
    set_regs(8'h12, 8'hFF, 1'b1);
    x_acc(OP_DATA_RD, CLS_OTHER, 16'h8000, 1'b0, 5'h00);
    x_acc(OP_DATA_RD, CLS_DOUBLE_MOVE, 16'hFFFE, 1'b0, 5'h00);
    x_acc(OP_DATA_RD, CLS_WORD_MOVE, 16'h7FFE, 1'b0, 5'h00);
    x_acc(OP_DATA_WR, CLS_OTHER, 16'h8000, 1'b0, 5'h00);
    for (int i = 0; i < 80; i++) begin
      r = xs();
      if (i % 8 == 0) set_regs(r[7:0], r[15:8], r[16] | r[17]);
      x_acc((r[20] & r[19]) ? OP_DATA_WR : OP_DATA_RD, psa_cls_e'(r[22:21]),
            {r[31:17], 1'b0}, 1'b0, r[0] ? {(r[1] ? 4'h1 << r[3:2] : 4'h0), 1'b1} : 5'h00);
    end
    $display("Test window done");
    results();
  end
endmodule
